// File: src/qbp_port_group.sv
// design: three 8-bit port pin drivers with alternate functions and edge interrupts
//
// Overview of operation
// RULE1 - low address/data port undriven after reset
// RULE2 - quasi port a latches reset to ones
// RULE3 - high address port latches reset to ones
// RULE4 - written zero enables strong pulldown until one
// RULE5 - zero-to-one write pulses strong pull-high briefly
// RULE6 - latched-one pin reads externally imposed level
// RULE7 - port a bit0 is timer2 external pin
// RULE8 - port a bit1 is timer2 capture trigger
// RULE9 - port a bits2,3 serial1 receive/transmit
// RULE10 - bits 4,6 rising-edge interrupts
// RULE11 - bits 5,7 falling-edge interrupts
// RULE12 - low port as I/O only pulls low
// RULE13 - address byte while strobe high, then data
// RULE14 - bus mode drives both levels actively
// RULE15 - high port outputs address msb during bus
// RULE16 - interrupt pins synchronised, sticky flags until cleared
`timescale 1ns/1ps
module qbp_port_group #(
  parameter int unsigned BOOST_CYCLES = qbp_pkg::BOOST_CYC
) (
  input  wire logic                 core_clk,      // core clock, 100 MHz
  input  wire logic                 rst_n,         // async reset, active low
  input  wire logic                 clk_en,        // freezes all state when low
  input  wire logic                 lad_wr,        // write low_addr_data_port latch
  input  wire logic                 qpa_wr,        // write quasi_port_a latch
  input  wire logic                 hap_wr,        // write high_addr_port latch
  input  wire logic [7:0]           wr_data,       // latch write data
  input  wire qbp_pkg::qbp_bus_req_t bus_req,      // external memory bus request
  input  wire logic                 timer2_ext_out_en, // timer2 drives its pin
  input  wire logic                 timer2_ext_out,    // timer2 pin value
  input  wire logic                 serial1_transmit_out, // serial1 tx bit
  input  wire logic                 serial1_tx_en, // serial1 owns tx pin
  input  wire logic [3:0]           irq_clr,       // clear sticky irq flags
  input  wire logic [7:0]           lad_in,        // low port pin levels
  input  wire logic [7:0]           qpa_in,        // quasi port a pin levels
  input  wire logic [7:0]           hap_in,        // high port pin levels
  output logic [7:0]                lad_out,       // low port pin drive value
  output logic [7:0]                lad_oe,        // low port drive enable
  output qbp_pkg::qbp_drive_t       qpa_drv,       // quasi port a drivers
  output qbp_pkg::qbp_drive_t       hap_drv,       // high port drivers
  output logic [7:0]                lad_rd,        // low port synced read
  output logic [7:0]                qpa_rd,        // quasi port a synced read
  output logic [7:0]                hap_rd,        // high port synced read
  output logic                      timer2_ext_pin, // synced timer2 pin
  output logic                      timer2_capture_reload_trigger, // synced trigger
  output logic                      serial1_receive_in, // synced serial1 rx
  output logic [3:0]                ext_irq_flag   // rise_a, fall_a, rise_b, fall_b
);

  //////////////////////////////////////////////////////////////////////////////
  // latches
  logic [7:0] lad_latch_ff;
  logic [7:0] qpa_latch_ff;
  logic [7:0] hap_latch_ff;

  // port latches; quasi ports come up at ones, low port latch too (open drain idle)
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lad_latch_ff <= qbp_pkg::LATCH_RST;
      qpa_latch_ff <= qbp_pkg::LATCH_RST;  // RULE2
      hap_latch_ff <= qbp_pkg::LATCH_RST;  // RULE3
    end else if (clk_en) begin
      if (lad_wr) lad_latch_ff <= wr_data;
      if (qpa_wr) qpa_latch_ff <= wr_data;  // RULE4
      if (hap_wr) hap_latch_ff <= wr_data;  // RULE4
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // strong pull-high pulse, one counter per bit per quasi port
  function automatic logic [7:0] rising_bits(input logic [7:0] old_v,
                                             input logic [7:0] new_v);
    return ~old_v & new_v;
  endfunction

  logic [qbp_pkg::BOOST_CNT_W-1:0] qpa_boost_ff [8];
  logic [qbp_pkg::BOOST_CNT_W-1:0] hap_boost_ff [8];
  logic [7:0] qpa_rise;
  logic [7:0] hap_rise;
  localparam logic [qbp_pkg::BOOST_CNT_W-1:0] BOOST_LOAD =
    qbp_pkg::BOOST_CNT_W'(BOOST_CYCLES);

  assign qpa_rise = qpa_wr ? rising_bits(qpa_latch_ff, wr_data) : qbp_pkg::ALL_OFF;
  assign hap_rise = hap_wr ? rising_bits(hap_latch_ff, wr_data) : qbp_pkg::ALL_OFF;

  // a zero-to-one write loads the count; a zero written clears it at once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        qpa_boost_ff[i] <= '0;
        hap_boost_ff[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < 8; i++) begin
        if (qpa_rise[i]) qpa_boost_ff[i] <= BOOST_LOAD;  // RULE5
        else if (qpa_wr && !wr_data[i]) qpa_boost_ff[i] <= '0;
        else if (qpa_boost_ff[i] != '0) qpa_boost_ff[i] <= qpa_boost_ff[i] - 1'b1;
        if (hap_rise[i]) hap_boost_ff[i] <= BOOST_LOAD;  // RULE5
        else if (hap_wr && !wr_data[i]) hap_boost_ff[i] <= '0;
        else if (hap_boost_ff[i] != '0) hap_boost_ff[i] <= hap_boost_ff[i] - 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin driver state
  logic [7:0] nxt_qpa_val;
  logic [7:0] boost_qpa;
  logic [7:0] boost_hap;
  logic [7:0] nxt_hap_val;
  logic       nxt_hap_bus;

  // alternate outputs override the latch value on bits 0 and 3
  always_comb begin
    nxt_qpa_val = qpa_latch_ff;
    if (timer2_ext_out_en) nxt_qpa_val[qbp_pkg::BIT_TMR2_PIN] = timer2_ext_out;  // RULE7
    if (serial1_tx_en) nxt_qpa_val[qbp_pkg::BIT_TXD] = serial1_transmit_out;  // RULE9
    for (int i = 0; i < 8; i++) begin
      boost_qpa[i] = (qpa_boost_ff[i] != '0);
      boost_hap[i] = (hap_boost_ff[i] != '0);
    end
    nxt_hap_bus = bus_req.active;
    nxt_hap_val = bus_req.active ? bus_req.addr[15:8] : hap_latch_ff;  // RULE15
  end

  // quasi ports: strong low on a latched zero, weak up otherwise, pulse on rise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      qpa_drv <= '{pull_low: 8'h00, pull_high: 8'h00, weak_up: 8'hFF};
      hap_drv <= '{pull_low: 8'h00, pull_high: 8'h00, weak_up: 8'hFF};
    end else if (clk_en) begin
      qpa_drv.pull_low  <= ~nxt_qpa_val;  // RULE4
      qpa_drv.pull_high <= boost_qpa & nxt_qpa_val;  // RULE5
      qpa_drv.weak_up   <= nxt_qpa_val;  // RULE6
      // during a bus cycle the address msb is driven hard both ways
      hap_drv.pull_low  <= ~nxt_hap_val;  // RULE4
      hap_drv.pull_high <= nxt_hap_bus ? nxt_hap_val : (boost_hap & nxt_hap_val);  // RULE15
      hap_drv.weak_up   <= nxt_hap_val;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // low address/data port: open drain as I/O, push-pull as bus
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lad_out <= 8'h00;
      lad_oe  <= 8'h00;  // RULE1
    end else if (clk_en) begin
      if (bus_req.active && bus_req.addr_phase) begin
        lad_out <= bus_req.addr[7:0];  // RULE13
        lad_oe  <= 8'hFF;  // RULE14
      end else if (bus_req.active) begin
        lad_out <= bus_req.wdata;  // RULE13
        lad_oe  <= {8{bus_req.drive_data}};  // RULE14
      end else begin
        lad_out <= 8'h00;  // RULE12
        lad_oe  <= ~lad_latch_ff;  // RULE12
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage read only by second
  logic [7:0] lad_s1_ff;
  logic [7:0] qpa_s1_ff;
  logic [7:0] hap_s1_ff;
  logic [7:0] qpa_s2_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lad_s1_ff <= 8'hFF;
      qpa_s1_ff <= 8'hFF;
      hap_s1_ff <= 8'hFF;
      lad_rd    <= 8'hFF;
      qpa_s2_ff <= 8'hFF;
      hap_rd    <= 8'hFF;
    end else if (clk_en) begin
      lad_s1_ff <= lad_in;
      qpa_s1_ff <= qpa_in;
      hap_s1_ff <= hap_in;
      lad_rd    <= lad_s1_ff;
      qpa_s2_ff <= qpa_s1_ff;  // RULE6
      hap_rd    <= hap_s1_ff;
    end
  end

  // registered copies for reads and alternate inputs, plus edge history
  logic [7:0] qpa_prev_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      qpa_rd                        <= 8'hFF;
      qpa_prev_ff                   <= 8'hFF;
      timer2_ext_pin                <= 1'b1;
      timer2_capture_reload_trigger <= 1'b1;
      serial1_receive_in            <= 1'b1;
    end else if (clk_en) begin
      qpa_rd                        <= qpa_s2_ff;  // RULE6
      qpa_prev_ff                   <= qpa_s2_ff;
      timer2_ext_pin                <= qpa_s2_ff[qbp_pkg::BIT_TMR2_PIN];  // RULE7
      timer2_capture_reload_trigger <= qpa_s2_ff[qbp_pkg::BIT_TMR2_TRIG];  // RULE8
      serial1_receive_in            <= qpa_s2_ff[qbp_pkg::BIT_RXD];  // RULE9
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // edge-detected interrupt flags; a new edge beats a clear in the same cycle
  logic [3:0] irq_edge;
  always_comb begin
    irq_edge[0] = qpa_s2_ff[qbp_pkg::BIT_IRQ_RA] & ~qpa_prev_ff[qbp_pkg::BIT_IRQ_RA];  // RULE10
    irq_edge[1] = ~qpa_s2_ff[qbp_pkg::BIT_IRQ_FA] & qpa_prev_ff[qbp_pkg::BIT_IRQ_FA];  // RULE11
    irq_edge[2] = qpa_s2_ff[qbp_pkg::BIT_IRQ_RB] & ~qpa_prev_ff[qbp_pkg::BIT_IRQ_RB];  // RULE10
    irq_edge[3] = ~qpa_s2_ff[qbp_pkg::BIT_IRQ_FB] & qpa_prev_ff[qbp_pkg::BIT_IRQ_FB];  // RULE11
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_irq_flag <= 4'h0;
    end else if (clk_en) begin
      ext_irq_flag <= irq_edge | (ext_irq_flag & ~irq_clr);  // RULE16
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  a_lad_reset_float: assert property (@(posedge core_clk)
    $rose(rst_n) |-> lad_oe == 8'h00)  // RULE1
    else $error("low port driven right after reset");

  a_qpa_zero_pull: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && qpa_wr ##1 clk_en && !timer2_ext_out_en && !serial1_tx_en
    |=> qpa_drv.pull_low == ~$past(wr_data, 2))  // RULE4
    else $error("quasi port pulldown does not follow written zeros");

  a_qpa_boost_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && qpa_wr && (qpa_latch_ff[5] == 1'b0) && wr_data[5]
    ##1 clk_en |=> qpa_drv.pull_high[5])  // RULE5
    else $error("no strong pull-high after zero-to-one write");

  a_qpa_no_contention: assert property (@(posedge core_clk) disable iff (!rst_n)
    (qpa_drv.pull_low & qpa_drv.pull_high) == 8'h00)  // RULE6
    else $error("quasi port drives high and low together");

  a_lad_open_drain: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !bus_req.active |=> lad_out == 8'h00)  // RULE12
    else $error("low port drove high outside bus mode");

  a_lad_addr_phase: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && bus_req.active && bus_req.addr_phase
    |=> lad_oe == 8'hFF && lad_out == $past(bus_req.addr[7:0]))  // RULE13
    else $error("address byte missing while strobe high");

  a_hap_addr_msb: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && bus_req.active
    |=> hap_drv.pull_high == $past(bus_req.addr[15:8]))  // RULE15
    else $error("high port not showing address msb");

  a_irq_rise_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && irq_edge[0] |=> ext_irq_flag[0])  // RULE10
    else $error("rising edge interrupt not flagged");

  a_irq_fall_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && $fell(qpa_s2_ff[qbp_pkg::BIT_IRQ_FB]) |=> ext_irq_flag[3])  // RULE11
    else $error("falling edge interrupt not flagged");

  a_irq_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    ext_irq_flag[1] && !irq_clr[1] |=> ext_irq_flag[1])  // RULE16
    else $error("interrupt flag dropped without clear");

endmodule // qbp_port_group

// File: src/qbp_pkg.sv
// package: constants and carrier types for the quasi-bidirectional port group
package qbp_pkg;
  localparam int unsigned PORT_W        = 8;
  localparam logic [7:0]  LATCH_RST     = 8'hFF;   // quasi ports reset to all ones
  localparam logic [7:0]  ALL_OFF       = 8'h00;
  // strong pull-high pulse length
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned BOOST_NS      = 20;
  localparam int unsigned BOOST_CYC_RAW = (BOOST_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BOOST_CYC     = (BOOST_CYC_RAW < 1) ? 1 : BOOST_CYC_RAW;
  localparam int unsigned BOOST_CNT_W   = 4;
  // alternate-function bit positions on quasi_port_a
  localparam int unsigned BIT_TMR2_PIN  = 0;
  localparam int unsigned BIT_TMR2_TRIG = 1;
  localparam int unsigned BIT_RXD       = 2;
  localparam int unsigned BIT_TXD       = 3;
  localparam int unsigned BIT_IRQ_RA    = 4;
  localparam int unsigned BIT_IRQ_FA    = 5;
  localparam int unsigned BIT_IRQ_RB    = 6;
  localparam int unsigned BIT_IRQ_FB    = 7;
  localparam int unsigned IRQ_N         = 4;

  // drive bundle of one 8-bit port: strong low, strong high, weak pullup
  typedef struct packed {
    logic [7:0] pull_low;
    logic [7:0] pull_high;
    logic [7:0] weak_up;
  } qbp_drive_t;

  // external memory bus request from the core
  typedef struct packed {
    logic       active;    // bus cycle in progress
    logic       addr_phase; // address latch strobe high
    logic       drive_data; // core writes data
    logic [15:0] addr;
    logic [7:0] wdata;
  } qbp_bus_req_t;
endpackage

// File: verif/qbp_pin_model.sv
// pin model: pull-up resistors and outside circuits that may pull port pins low
`timescale 1ns/1ps
module qbp_pin_model (
  qbp_drv_a,  // port a drivers
  qbp_drv_h,  // high port drivers
  lad_out,    // low port drive value
  lad_oe,     // low port drive enable
  ext_qpa,    // outside pulls port a low
  ext_hap,    // outside pulls high port low
  ext_lad,    // outside pulls low port low
  qpa_pin,    // port a pin level
  hap_pin,    // high port pin level
  lad_pin     // low port pin level
);
  input  wire qbp_pkg::qbp_drive_t qbp_drv_a;
  input  wire qbp_pkg::qbp_drive_t qbp_drv_h;
  input  wire logic [7:0]          lad_out;
  input  wire logic [7:0]          lad_oe;
  input  wire logic [7:0]          ext_qpa;
  input  wire logic [7:0]          ext_hap;
  input  wire logic [7:0]          ext_lad;
  output logic [7:0]               qpa_pin;
  output logic [7:0]               hap_pin;
  output logic [7:0]               lad_pin;
  ////////////////////////////////////////////////////////////////////////////////
  // every pin has a pull-up, so a released pin rests high; a low always wins
  always_comb begin
    qpa_pin = ~(qbp_drv_a.pull_low | ext_qpa);
    hap_pin = ~(qbp_drv_h.pull_low | ext_hap);
    lad_pin = ~((lad_oe & ~lad_out) | ext_lad);
  end
endmodule // qbp_pin_model

// File: verif/quasi_bidir_port_group_tb_top.sv
// testbench: scenario tasks for the port group with a pin model
`timescale 1ns/1ps
module quasi_bidir_port_group_tb_top;
  localparam int BOOST = 3;  // lengthened pull-high pulse (package default is 2 cycles)
  logic core_clk = 0, rst_n = 0, lad_wr = 0, qpa_wr = 0, hap_wr = 0;
  logic tmr2_en = 0, tmr2_out = 1, tx_en = 0, tx_out = 1, clk_en = 1;
  logic [7:0] wr_data = 8'h00, ext_qpa = 8'h00, ext_hap = 8'h00;
  logic [3:0] irq_clr = 4'h0;
  qbp_pkg::qbp_bus_req_t bus_req = '0;
  qbp_pkg::qbp_drive_t   qpa_drv, hap_drv;
  logic [7:0] lad_out, lad_oe, lad_rd, qpa_rd, hap_rd, qpa_pin, hap_pin, lad_pin;
  logic       tmr2_pin, tmr2_trig, rx_in;
  logic [3:0] ext_irq_flag;
  int fail_count = 0, checks_done = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  qbp_port_group #(.BOOST_CYCLES(BOOST)) qbp_port_group_i (.core_clk(core_clk),
    .rst_n(rst_n), .clk_en(clk_en), .lad_wr(lad_wr), .qpa_wr(qpa_wr), .hap_wr(hap_wr),
    .wr_data(wr_data), .bus_req(bus_req), .timer2_ext_out_en(tmr2_en),
    .timer2_ext_out(tmr2_out), .serial1_transmit_out(tx_out), .serial1_tx_en(tx_en),
    .irq_clr(irq_clr), .lad_in(lad_pin), .qpa_in(qpa_pin), .hap_in(hap_pin),
    .lad_out(lad_out), .lad_oe(lad_oe), .qpa_drv(qpa_drv), .hap_drv(hap_drv),
    .lad_rd(lad_rd), .qpa_rd(qpa_rd), .hap_rd(hap_rd), .timer2_ext_pin(tmr2_pin),
    .timer2_capture_reload_trigger(tmr2_trig), .serial1_receive_in(rx_in),
    .ext_irq_flag(ext_irq_flag));
  qbp_pin_model qbp_pin_model_i (.qbp_drv_a(qpa_drv), .qbp_drv_h(hap_drv),
    .lad_out(lad_out), .lad_oe(lad_oe), .ext_qpa(ext_qpa), .ext_hap(ext_hap),
    .ext_lad(8'h00), .qpa_pin(qpa_pin), .hap_pin(hap_pin), .lad_pin(lad_pin));
  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers: inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // the extra edge after the strobe keeps back-to-back writes apart
  task automatic wr(input int p, input logic [7:0] d);
    wr_data = d;
    lad_wr = (p == 0);
    qpa_wr = (p == 1);
    hap_wr = (p == 2);
    step(1);
    {lad_wr, qpa_wr, hap_wr} = 3'b000;
    step(1);
  endtask
  // field 0 strong low, 1 strong high, 2 weak pullup; port 1 quasi a, port 2 high
  function automatic logic [7:0] drv(input int p, input int f);
    qbp_pkg::qbp_drive_t d;
    d = (p == 1) ? qpa_drv : hap_drv;
    return (f == 0) ? d.pull_low : ((f == 1) ? d.pull_high : d.weak_up);
  endfunction
  task automatic finish_test;
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    chk("lad_oe", 8'h00, lad_oe);
    chk("qpa_weak", 8'hFF, qpa_drv.weak_up);
    chk("qpa_low", 8'h00, qpa_drv.pull_low);
    chk("hap_weak", 8'hFF, hap_drv.weak_up);
    chk("hap_low", 8'h00, hap_drv.pull_low);
  endtask
  // with the clock enable low a write must be lost, not just delayed
  task automatic t_freeze;
    clk_en = 1'b0;
    wr(1, 8'h00);
    chk("frozen_low", 8'h00, qpa_drv.pull_low);
    clk_en = 1'b1;
    step(2);
    chk("frozen_lost", 8'h00, qpa_drv.pull_low);
  endtask
  // only bits that held zero may get the strong pull-high pulse
  task automatic t_quasi(input int p, input logic [7:0] v);
    wr(p, v);
    chk("pull_low", ~v, drv(p, 0));
    step(4);
    chk("pull_low_hold", ~v, drv(p, 0));
    wr(p, 8'hFF);
    chk("pull_low_off", 8'h00, drv(p, 0));
    chk("weak_up", 8'hFF, drv(p, 2));
    for (int i = 0; i < BOOST; i++) begin
      chk("pull_high", ~v, drv(p, 1));
      step(1);
    end
    chk("pull_high_off", 8'h00, drv(p, 1));
  endtask
  task automatic t_input;
    ext_qpa = 8'h81;
    ext_hap = 8'h18;
    step(5);
    chk("qpa_rd", 8'h7E, qpa_rd);
    chk("hap_rd", 8'hE7, hap_rd);
    {ext_qpa, ext_hap} = 16'h0000;
    step(5);
  endtask
  task automatic t_alt;
    {tmr2_en, tmr2_out, tx_en, tx_out} = 4'hA;
    ext_qpa = 8'h07;
    step(5);
    chk("alt_drive", 8'h09, qpa_drv.pull_low);
    chk("alt_in", 8'h00, {5'h00, rx_in, tmr2_trig, tmr2_pin});
    {tmr2_out, tx_out} = 2'h3;
    ext_qpa = 8'h00;
    step(5);
    chk("alt_drive_hi", 8'h00, qpa_drv.pull_low);
    chk("alt_in_hi", 8'h07, {5'h00, rx_in, tmr2_trig, tmr2_pin});
    {tmr2_en, tx_en} = 2'h0;
    step(1);
  endtask
  task automatic t_irq;
    irq_clr = 4'hF;
    step(1);
    irq_clr = 4'h0;
    step(1);
    chk("irq_clear", 8'h00, {4'h0, ext_irq_flag});
    ext_qpa = 8'hF0;
    step(6);
    chk("irq_fall", 8'h0A, {4'h0, ext_irq_flag});
    irq_clr = 4'hA;
    step(1);
    irq_clr = 4'h0;
    ext_qpa = 8'h00;
    step(6);
    chk("irq_rise", 8'h05, {4'h0, ext_irq_flag});
    step(8);
    chk("irq_sticky", 8'h05, {4'h0, ext_irq_flag});
  endtask
  task automatic t_bus;
    wr(0, 8'h0F);
    chk("io_oe", 8'hF0, lad_oe);
    chk("io_out", 8'h00, lad_out);
    bus_req = '{active: 1'b1, addr_phase: 1'b1, drive_data: 1'b0,
                addr: 16'hA55A, wdata: 8'hC3};
    step(1);
    chk("addr_oe", 8'hFF, lad_oe);
    chk("addr_lo", 8'h5A, lad_out);
    chk("addr_hi", 8'hA5, hap_drv.pull_high);
    chk("addr_hi_n", 8'h5A, hap_drv.pull_low);
    bus_req.addr_phase = 1'b0;
    bus_req.drive_data = 1'b1;
    step(1);
    chk("data_out", 8'hC3, lad_out);
    chk("data_oe", 8'hFF, lad_oe);
    bus_req.drive_data = 1'b0;
    step(1);
    chk("data_rd_oe", 8'h00, lad_oe);
    bus_req = '0;
    step(1);
    chk("io_back", 8'hF0, lad_oe);
    step(2);
    chk("lad_rd", 8'h0F, lad_rd);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // hang guard: the sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    #1 rst_n = 1;
    step(1);
    t_reset();
    t_freeze();
    t_quasi(1, 8'h0F);
    t_quasi(2, 8'h3C);
    t_input();
    t_alt();
    t_irq();
    t_bus();
    finish_test();
  end
endmodule // quasi_bidir_port_group_tb_top
